// file: core/srb_pkg.sv
// Package for the serial receive ring buffer and status block
package srb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, one byte each on a 4-bit address
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_BUF0 = 4'h0;
  localparam logic [3:0] OFS_BUF1 = 4'h1;
  localparam logic [3:0] OFS_BUF2 = 4'h2;
  localparam logic [3:0] OFS_BUF3 = 4'h3;
  localparam logic [3:0] OFS_STAT0 = 4'h4;
  localparam logic [3:0] OFS_RXCTRL = 4'h5;
  localparam logic [3:0] OFS_RING_STAT = 4'h6;
  localparam logic [3:0] OFS_FLAG12 = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Status register 0 fields
  localparam int ST_FERR = 0;
  localparam int ST_ERR_LO = 1;
  localparam int ST_RX_IE = 4;
  localparam int ST_RX_REQ = 5;
  localparam int ST_TX_IE = 6;
  localparam int ST_TX_REQ = 7;
  localparam logic [7:0] STAT0_RESET = 8'h00;

  // Receive control fields
  localparam int RC_MP_MODE = 0;
  localparam int RC_ADDR_SEL = 2;
  localparam int RC_RING = 3;
  localparam int RC_PAR_EN = 5;
  localparam int RC_PAR_EVEN = 6;
  localparam int RC_RX_EN = 7;
  localparam logic [7:0] RXCTRL_RESET = 8'h12;

  // Ring status fields: buffer 3 flags low, pointer at 5:4
  localparam int RS_PTR_LO = 4;
  localparam int FL_BUF2_LO = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SRB_RX_IDLE = 2'b00,
    SRB_RX_DATA = 2'b01,
    SRB_RX_EXTRA = 2'b10,
    SRB_RX_STOP = 2'b11
  } srb_rx_state_t;

  typedef enum logic [1:0] {
    SRB_TX_IDLE = 2'b00,
    SRB_TX_START = 2'b01,
    SRB_TX_DATA = 2'b10,
    SRB_TX_STOP = 2'b11
  } srb_tx_state_t;

  // One finished frame from the receive shift register
  typedef struct packed {
    logic [7:0] data;
    logic extra;
    logic stop;
  } srb_frame_t;

  // Per-buffer error flags
  typedef struct packed {
    logic merr;
    logic perr;
    logic oerr;
  } srb_err_t;

endpackage

// file: core/srb_rx_shift.sv
// Receive shift register with line synchroniser
module srb_rx_shift (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Line and timing
  input wire logic rx_pin,
  input wire logic bit_tick,
  // Configuration
  input wire logic rx_enable,
  input wire logic extra_en,
  // Finished frame
  output logic done,
  output srb_pkg::srb_frame_t frame
);

  logic sync1, line;
  srb_pkg::srb_rx_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic extra, next_extra, next_done;
  srb_pkg::srb_frame_t next_frame;

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    sync1 <= rx_pin;
    line <= sync1;
  end

  // Sample once per bit tick; tick must fall near mid-bit
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_extra = extra;
    next_done = 1'b0;
    next_frame = frame;
    if (bit_tick) begin
      case (state)
        srb_pkg::SRB_RX_IDLE: begin
          if (rx_enable && !line) begin
            next_state = srb_pkg::SRB_RX_DATA;
            next_cnt = 3'h0;
            next_extra = 1'b0;
          end
        end
        srb_pkg::SRB_RX_DATA: begin
          next_shift = {line, shift[7:1]}; // LSB first
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7) begin
            next_state = extra_en ? srb_pkg::SRB_RX_EXTRA :
                                    srb_pkg::SRB_RX_STOP;
          end
        end
        srb_pkg::SRB_RX_EXTRA: begin
          next_extra = line;
          next_state = srb_pkg::SRB_RX_STOP;
        end
        srb_pkg::SRB_RX_STOP: begin
          next_frame = '{data: shift, extra: extra, stop: line};
          next_done = 1'b1;
          next_state = srb_pkg::SRB_RX_IDLE;
        end
        default: next_state = srb_pkg::SRB_RX_IDLE;
      endcase
    end
  end

  // State registers, hidden from software
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= srb_pkg::SRB_RX_IDLE;
      cnt <= 3'h0;
      shift <= 8'h00;
      extra <= 1'b0;
      done <= 1'b0;
      frame <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      extra <= next_extra;
      done <= next_done;
      frame <= next_frame;
    end
  end

endmodule

// file: core/srb_tx_shift.sv
// Transmit shift register, start, eight data bits, stop
module srb_tx_shift (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Timing
  input wire logic bit_tick,
  // Load side
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic busy,
  // Line
  output logic tx_pin
);

  srb_pkg::srb_tx_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shift, next_shift;
  logic next_pin;

  assign busy = (state != srb_pkg::SRB_TX_IDLE);

  // Load only while idle, then shift on ticks
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_pin = tx_pin;
    case (state)
      srb_pkg::SRB_TX_IDLE: begin
        next_pin = 1'b1;
        if (load) begin
          next_shift = load_data;
          next_state = srb_pkg::SRB_TX_START;
        end
      end
      srb_pkg::SRB_TX_START: begin
        if (bit_tick) begin
          next_pin = 1'b0;
          next_cnt = 3'h0;
          next_state = srb_pkg::SRB_TX_DATA;
        end
      end
      srb_pkg::SRB_TX_DATA: begin
        if (bit_tick) begin
          next_pin = shift[0];
          next_shift = {1'b0, shift[7:1]};
          next_cnt = cnt + 3'h1;
          if (cnt == 3'h7) begin
            next_state = srb_pkg::SRB_TX_STOP;
          end
        end
      end
      srb_pkg::SRB_TX_STOP: begin
        if (bit_tick) begin
          next_pin = 1'b1;
          next_state = srb_pkg::SRB_TX_IDLE;
        end
      end
      default: next_state = srb_pkg::SRB_TX_IDLE;
    endcase
  end

  // Line idles high from reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= srb_pkg::SRB_TX_IDLE;
      cnt <= 3'h0;
      shift <= 8'h00;
      tx_pin <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      tx_pin <= next_pin;
    end
  end

endmodule

// file: core/srb_top.sv
// Serial channel four receive buffers, status and request flags
//
// Operation
// - finished reception loads buffer 0, raises request
// - buffer 0 holds until next reception
// - ignored multiprocessor frame leaves buffer 0 alone
// - buffers 1-3 read-only, used in ring mode
// - ring mode fills buffers 0,1,2,3 cyclically
// - ignored frame touches no ring buffer
// - two hidden 8-bit shift registers
// - low status bits update per reception
// - error flags sticky until software clears
// - unread buffer re-sets overrun after clear
// - per-buffer errors, one shared framing flag
// - stop bit zero sets framing flag
// - overrun when previous byte unread, still overwrite
// - parity mismatch sets parity flag
// - marker one while expecting data sets flag
// - bit 4 enables receive-ready request
// - receive-ready flag sticky, software clears
// - bit 6 enables transmit-ready request
// - transmit-ready flag sticky, software clears
// - any reset clears status, buffers undefined
// - control bit 3 selects ring mode
// - address select picks data or address frames
module srb_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // Serial line and bit timing
  input wire logic rx_pin,
  input wire logic rx_bit_tick,
  input wire logic tx_bit_tick,
  output logic tx_pin,
  // Request outputs
  output logic rx_irq,
  output logic tx_irq
);

  logic [7:0] rx_buf [0:3];
  logic [7:0] rx_ctrl, next_rx_ctrl;
  srb_pkg::srb_err_t flags [0:3];
  srb_pkg::srb_err_t next_flags [0:3];
  logic ferr, next_ferr;
  logic rx_ie, next_rx_ie, tx_ie, next_tx_ie;
  logic rx_req, next_rx_req, tx_req, next_tx_req;
  logic [1:0] ptr, next_ptr;
  logic [3:0] unread, next_unread;
  logic [7:0] tx_hold, next_tx_hold;
  logic tx_full, next_tx_full;
  logic [7:0] next_rd_data;
  logic rx_done, tx_busy, tx_load;
  srb_pkg::srb_frame_t frame;
  logic mp_mode, addr_sel, ring, ignored, store;
  logic [1:0] idx;
  logic par_err, mp_err;
  logic wr_stat0, wr_ctrl;

  // Expected parity bit over a data byte
  function automatic logic parity_bit(input logic [7:0] d,
                                      input logic even);
    parity_bit = even ? (^d) : ~(^d);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers
  srb_rx_shift u_rx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rx_pin(rx_pin),
    .bit_tick(rx_bit_tick),
    .rx_enable(rx_ctrl[srb_pkg::RC_RX_EN]),
    .extra_en(mp_mode | rx_ctrl[srb_pkg::RC_PAR_EN]),
    .done(rx_done),
    .frame(frame)
  );

  srb_tx_shift u_tx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .bit_tick(tx_bit_tick),
    .load(tx_load),
    .load_data(tx_hold),
    .busy(tx_busy),
    .tx_pin(tx_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame classification
  assign mp_mode = rx_ctrl[srb_pkg::RC_MP_MODE];
  assign addr_sel = rx_ctrl[srb_pkg::RC_ADDR_SEL];
  assign ring = rx_ctrl[srb_pkg::RC_RING];
  // Address wanted but a data frame came: drop it silently
  assign ignored = rx_done && mp_mode && addr_sel && !frame.extra;
  assign store = rx_done && !ignored;
  assign idx = ring ? ptr : 2'h0;
  assign par_err = rx_ctrl[srb_pkg::RC_PAR_EN] && !mp_mode &&
    (frame.extra != parity_bit(frame.data,
                               rx_ctrl[srb_pkg::RC_PAR_EVEN]));
  assign mp_err = mp_mode && !addr_sel && frame.extra;
  assign wr_stat0 = wr_en && (addr == srb_pkg::OFS_STAT0);
  assign wr_ctrl = wr_en && (addr == srb_pkg::OFS_RXCTRL);
  // Transmit hold hands to the shifter when it is free
  assign tx_load = tx_full && !tx_busy;

  // Request outputs gated by their enables
  assign rx_irq = rx_req && rx_ie;
  assign tx_irq = tx_req && tx_ie;

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffers carry no reset, so they read undefined after it
  always_ff @(posedge sys_clk) begin
    if (store) begin
      rx_buf[idx] <= frame.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, control and bookkeeping; hardware set wins over a clear
  always_comb begin
    next_rx_ctrl = rx_ctrl;
    next_ferr = ferr;
    next_rx_ie = rx_ie;
    next_tx_ie = tx_ie;
    next_rx_req = rx_req;
    next_tx_req = tx_req;
    next_ptr = ptr;
    next_unread = unread;
    next_tx_hold = tx_hold;
    next_tx_full = tx_full;
    for (int i = 0; i < 4; i++) begin
      next_flags[i] = flags[i];
    end
    // Software writes first
    if (wr_ctrl) begin
      next_rx_ctrl = wr_data;
    end
    if (wr_stat0) begin
      next_ferr = wr_data[srb_pkg::ST_FERR];
      next_flags[0] = wr_data[srb_pkg::ST_ERR_LO +: 3];
      next_rx_ie = wr_data[srb_pkg::ST_RX_IE];
      next_rx_req = wr_data[srb_pkg::ST_RX_REQ];
      next_tx_ie = wr_data[srb_pkg::ST_TX_IE];
      next_tx_req = wr_data[srb_pkg::ST_TX_REQ];
    end
    if (wr_en && addr == srb_pkg::OFS_RING_STAT) begin
      next_flags[3] = wr_data[srb_pkg::ST_ERR_LO +: 3];
    end
    if (wr_en && addr == srb_pkg::OFS_FLAG12) begin
      next_flags[1] = wr_data[srb_pkg::ST_ERR_LO +: 3];
      next_flags[2] = wr_data[srb_pkg::FL_BUF2_LO +: 3];
    end
    // Buffer 0 write is the transmit side; buffers 1-3 ignore writes
    if (wr_en && addr == srb_pkg::OFS_BUF0) begin
      next_tx_hold = wr_data;
      next_tx_full = 1'b1;
    end else if (tx_load) begin
      next_tx_full = 1'b0;
    end
    if (tx_load) begin
      next_tx_req = 1'b1;
    end
    // A read of a buffer marks it consumed
    if (rd_en && addr[3:2] == 2'b00) begin
      next_unread[addr[1:0]] = 1'b0;
    end
    // Reception results; flags only ever OR in
    if (store) begin
      // Unread slot sets overrun, even right after a clear
      next_flags[idx].oerr = next_flags[idx].oerr | unread[idx];
      next_flags[idx].perr = next_flags[idx].perr | par_err;
      next_flags[idx].merr = next_flags[idx].merr | mp_err;
      next_ferr = next_ferr | !frame.stop;
      next_unread[idx] = 1'b1;
      next_rx_req = 1'b1;
      next_ptr = ring ? ptr + 2'h1 : 2'h0;
    end else if (!ring) begin
      next_ptr = 2'h0;
    end
  end

  // Any reset source arrives as rstn and clears status
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_ctrl <= srb_pkg::RXCTRL_RESET;
      ferr <= srb_pkg::STAT0_RESET[srb_pkg::ST_FERR];
      rx_ie <= srb_pkg::STAT0_RESET[srb_pkg::ST_RX_IE];
      tx_ie <= srb_pkg::STAT0_RESET[srb_pkg::ST_TX_IE];
      rx_req <= srb_pkg::STAT0_RESET[srb_pkg::ST_RX_REQ];
      tx_req <= srb_pkg::STAT0_RESET[srb_pkg::ST_TX_REQ];
      ptr <= 2'h0;
      unread <= 4'h0;
      tx_hold <= 8'h00;
      tx_full <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        flags[i] <= '0;
      end
    end else begin
      rx_ctrl <= next_rx_ctrl;
      ferr <= next_ferr;
      rx_ie <= next_rx_ie;
      tx_ie <= next_tx_ie;
      rx_req <= next_rx_req;
      tx_req <= next_tx_req;
      ptr <= next_ptr;
      unread <= next_unread;
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
      for (int i = 0; i < 4; i++) begin
        flags[i] <= next_flags[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en) begin
      case (addr)
        srb_pkg::OFS_BUF0: next_rd_data = rx_buf[0];
        srb_pkg::OFS_BUF1: next_rd_data = rx_buf[1];
        srb_pkg::OFS_BUF2: next_rd_data = rx_buf[2];
        srb_pkg::OFS_BUF3: next_rd_data = rx_buf[3];
        srb_pkg::OFS_STAT0: next_rd_data = {tx_req, tx_ie, rx_req, rx_ie,
                                            flags[0], ferr};
        srb_pkg::OFS_RXCTRL: next_rd_data = rx_ctrl;
        srb_pkg::OFS_RING_STAT: next_rd_data = {2'b00, ptr, flags[3], 1'b0};
        srb_pkg::OFS_FLAG12: next_rd_data = {flags[2], 1'b0, flags[1], 1'b0};
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic seen0;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seen0 <= 1'b0;
    end else if (store && idx == 2'h0) begin
      seen0 <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_store_sets_req: assert property (store |=> rx_req)
    else $error("reception did not raise receive request");
  a_buf0_holds: assert property (
    seen0 && !(store && idx == 2'h0) |=> rx_buf[0] == $past(rx_buf[0]))
    else $error("buffer 0 changed without reception");
  a_ignored_quiet: assert property (
    ignored && !rx_req && !wr_stat0 |=> !rx_req && ptr == $past(ptr))
    else $error("ignored frame raised request or moved ring");
  a_ring_advance: assert property (
    store && ring |=> ptr == $past(ptr) + 2'h1)
    else $error("ring pointer did not advance");
  a_err_sticky: assert property (
    flags[0].perr && !wr_stat0 |=> flags[0].perr)
    else $error("parity flag dropped without a write");
  a_overrun_buf0: assert property (
    store && idx == 2'h0 && unread[0]
    |=> flags[0].oerr ##1 unread[0] || $past(rd_en))
    else $error("overrun not flagged on unread buffer 0");
  a_framing_set: assert property (store && !frame.stop |=> ferr)
    else $error("framing flag not set on zero stop bit");
  a_rx_irq_gate: assert property (
    store && rx_ie && !wr_stat0 |=> rx_irq)
    else $error("receive request output not raised");
  a_tx_req_set: assert property (tx_load |=> tx_req && tx_busy)
    else $error("transmit ready flag not set on load");

  // Ring slots, pointer and per-buffer flags
  a_buf1_ro: assert property (
    wr_en && addr == srb_pkg::OFS_BUF1 && !(store && idx == 2'h1)
    |=> rx_buf[1] == $past(rx_buf[1]))
    else $error("write reached receive buffer 1");
  a_ignored_ring: assert property (
    ignored && ring && !wr_ctrl && !rd_en
    |=> ptr == $past(ptr) && unread == $past(unread))
    else $error("ignored frame touched a ring buffer");
  a_flags0_apart: assert property (
    store && idx != 2'h0 && !flags[0].perr && !wr_stat0 |=> !flags[0].perr)
    else $error("buffer 0 flag set by another buffer");
  a_overrun_ring: assert property (
    store && unread[idx] |=> flags[$past(idx)].oerr)
    else $error("overrun not flagged on unread ring buffer");
  a_unread_kept: assert property (
    wr_stat0 && unread[0] && !(rd_en && addr == srb_pkg::OFS_BUF0)
    |=> unread[0])
    else $error("clear of overrun forgot unread buffer 0");
  a_ptr_single: assert property (!ring |=> ptr == 2'h0)
    else $error("ring pointer moved in single buffer mode");

  // Error detection against the raw frame bits, then sticky flags
  a_parity_set: assert property (
    store && rx_ctrl[srb_pkg::RC_PAR_EN] && !mp_mode &&
    (^{frame.data, frame.extra}) == rx_ctrl[srb_pkg::RC_PAR_EVEN]
    |=> flags[$past(idx)].perr)
    else $error("parity mismatch not flagged");
  a_mp_err_set: assert property (
    store && mp_mode && !addr_sel && frame.extra |=> flags[$past(idx)].merr)
    else $error("address frame in data mode not flagged");
  a_ferr_sticky: assert property (ferr && !wr_stat0 |=> ferr)
    else $error("framing flag dropped without a write");
  a_rx_req_sticky: assert property (
    rx_req && !wr_stat0 |=> rx_req)
    else $error("receive ready flag dropped without a write");
  a_tx_req_sticky: assert property (
    tx_req && !wr_stat0 |=> tx_req)
    else $error("transmit ready flag dropped without a write");

  // Request outputs follow flag and enable
  a_rx_irq_off: assert property (!rx_ie |-> !rx_irq)
    else $error("receive request output while disabled");
  a_tx_irq_off: assert property (!tx_ie |-> !tx_irq)
    else $error("transmit request output while disabled");
  a_tx_irq_on: assert property (tx_req && tx_ie |-> tx_irq)
    else $error("transmit request output not raised");

  c_ring_wrap: cover property (store && ring && ptr == 2'h3);
  c_overrun: cover property (store && unread[idx]);
  c_ignored: cover property (ignored);
  c_tx_frame: cover property (tx_load ##1 tx_busy);
  c_ring_parity: cover property (store && idx == 2'h1 && par_err);

endmodule

// file: verification/srb_line_model.sv
// Remote serial transmitter model that drives the receive line
module srb_line_model (
  // Clock
  input wire logic sys_clk,
  // Line and bit timing toward the block
  output logic rx_pin,
  output logic bit_tick
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] phase = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Eight cycles a bit; tick mid-bit so the two-flop lag has settled
  always @(posedge sys_clk) begin
    phase <= phase + 3'h1;
  end
  assign bit_tick = (phase == 3'h4);
  initial rx_pin = 1'b1; // Line idles high between frames

  // Hold one bit for a whole bit period, changed just after an edge
  task automatic put_bit(input logic b);
    do @(posedge sys_clk); while (phase != 3'h7);
    rx_pin <= b;
  endtask

  // Start, eight data bits LSB first, optional marker or parity, stop
  task automatic send(input logic [7:0] d, input logic use_x,
                      input logic x, input logic stop);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (use_x) put_bit(x);
    put_bit(stop);
    put_bit(1'b1); // Idle bit so a zero stop never merges with a start
  endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the receive buffers and status block
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk;
  logic rstn;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic rx_pin;
  logic tick;
  logic tx_pin;
  logic rx_irq;
  logic tx_irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] rb[4];
  logic [7:0] tx_q[$];
  logic [7:0] tx_sh = 8'h00;
  int tx_n = 0;
  int n_mismatch = 0;
  int n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design, line partner and clock
  srb_top u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin),
    .rx_bit_tick(tick), .tx_bit_tick(tick), .tx_pin(tx_pin),
    .rx_irq(rx_irq), .tx_irq(tx_irq)
  );
  srb_line_model u_line (.sys_clk(sys_clk), .rx_pin(rx_pin), .bit_tick(tick));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe; look mid-cycle
  always @(posedge sys_clk) begin
    rd_q <= rd_en;
  end
  always @(negedge sys_clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) cmp("rd_data unexpected", 8'h00, 8'hFF);
      else cmp("rd_data", exp_q.pop_front(), rd_data);
    end
  end

  // Transmit line: each bit looked at mid-cycle just before its end tick
  always @(negedge sys_clk) begin
    if (!rstn) begin
      tx_n <= 0;
    end else if (tick) begin
      if (tx_n == 0) begin
        if (!tx_pin) tx_n <= 1;
      end else if (tx_n < 9) begin
        tx_sh <= {tx_pin, tx_sh[7:1]};
        tx_n <= tx_n + 1;
      end else begin
        tx_n <= 0;
        cmp("tx_pin stop", 8'h01, {7'h00, tx_pin});
        if (tx_q.size() == 0) cmp("tx_pin unexpected", 8'h00, 8'hFF);
        else cmp("tx_pin data", tx_q.pop_front(), tx_sh);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port master: one-cycle strobes, changed after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // The expectation is noted before the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  // Request outputs are levels; look once the last write has landed
  task automatic irq(input logic erx, input logic etx);
    @(negedge sys_clk);
    cmp("rx_irq", {7'h00, erx}, {7'h00, rx_irq});
    cmp("tx_irq", {7'h00, etx}, {7'h00, tx_irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the roughly 2000 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    void'($urandom(32'h0d7f96cb));
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(srb_pkg::OFS_STAT0, 8'h00);
    rd(srb_pkg::OFS_RXCTRL, 8'h12);
    // Single buffer: store, request, enable and sticky request
    wr(srb_pkg::OFS_RXCTRL, 8'h80);
    u_line.send(8'hA5, 1'b0, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h20);
    rd(srb_pkg::OFS_BUF0, 8'hA5);
    irq(1'b0, 1'b0);
    wr(srb_pkg::OFS_STAT0, 8'h30);
    irq(1'b1, 1'b0);
    wr(srb_pkg::OFS_STAT0, 8'h10);
    irq(1'b0, 1'b0);
    rd(srb_pkg::OFS_BUF0, 8'hA5);
    // Overrun, then a clear made without reading first
    u_line.send(8'h3C, 1'b0, 1'b0, 1'b1);
    u_line.send(8'hC3, 1'b0, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h32);
    wr(srb_pkg::OFS_STAT0, 8'h10);
    u_line.send(8'h5A, 1'b0, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h32);
    rd(srb_pkg::OFS_BUF0, 8'h5A);
    wr(srb_pkg::OFS_STAT0, 8'h10);
    u_line.send(8'h66, 1'b0, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h30);
    rd(srb_pkg::OFS_BUF0, 8'h66);
    // Framing error stays through a clean frame
    u_line.send(8'h77, 1'b0, 1'b0, 1'b0);
    rd(srb_pkg::OFS_STAT0, 8'h31);
    rd(srb_pkg::OFS_BUF0, 8'h77);
    u_line.send(8'h78, 1'b0, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h31);
    rd(srb_pkg::OFS_BUF0, 8'h78);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    // Parity: even with a wrong bit, odd with a right one
    wr(srb_pkg::OFS_RXCTRL, 8'hE0);
    u_line.send(8'h01, 1'b1, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h24);
    rd(srb_pkg::OFS_BUF0, 8'h01);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    wr(srb_pkg::OFS_RXCTRL, 8'hA0);
    u_line.send(8'h03, 1'b1, 1'b1, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h20);
    rd(srb_pkg::OFS_BUF0, 8'h03);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    // Multiprocessor: address while expecting data, ignored, accepted
    wr(srb_pkg::OFS_RXCTRL, 8'h81);
    u_line.send(8'h9E, 1'b1, 1'b1, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h28);
    rd(srb_pkg::OFS_BUF0, 8'h9E);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    wr(srb_pkg::OFS_RXCTRL, 8'h85);
    u_line.send(8'h44, 1'b1, 1'b0, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h00);
    rd(srb_pkg::OFS_BUF0, 8'h9E);
    u_line.send(8'h45, 1'b1, 1'b1, 1'b1);
    rd(srb_pkg::OFS_STAT0, 8'h20);
    rd(srb_pkg::OFS_BUF0, 8'h45);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    // Ring of four with random bytes
    wr(srb_pkg::OFS_RXCTRL, 8'h88);
    rd(srb_pkg::OFS_RING_STAT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rb[i] = 8'($urandom);
      u_line.send(rb[i], 1'b0, 1'b0, 1'b1);
      if (i == 0) rd(srb_pkg::OFS_RING_STAT, 8'h10);
    end
    rd(srb_pkg::OFS_RING_STAT, 8'h00);
    wr(srb_pkg::OFS_BUF1, ~rb[1]);
    for (int i = 0; i < 4; i++) rd(4'(i), rb[i]);
    rd(srb_pkg::OFS_STAT0, 8'h20);
    wr(srb_pkg::OFS_STAT0, 8'h00);
    u_line.send(8'hB4, 1'b0, 1'b0, 1'b0);
    rd(srb_pkg::OFS_STAT0, 8'h21);
    wr(srb_pkg::OFS_RXCTRL, 8'h8D);
    u_line.send(8'h12, 1'b1, 1'b0, 1'b1);
    rd(srb_pkg::OFS_RING_STAT, 8'h10);
    rd(srb_pkg::OFS_STAT0, 8'h21);
    // Ring slot 1 keeps its own parity flag
    wr(srb_pkg::OFS_RXCTRL, 8'hE8);
    u_line.send(8'h01, 1'b1, 1'b0, 1'b1);
    rd(srb_pkg::OFS_FLAG12, 8'h04);
    rd(srb_pkg::OFS_STAT0, 8'h21);
    wr(srb_pkg::OFS_FLAG12, 8'h00);
    rd(srb_pkg::OFS_FLAG12, 8'h00);
    // Transmit-ready request, its enable and stickiness
    wr(srb_pkg::OFS_STAT0, 8'h40);
    tx_q.push_back(8'h55);
    wr(srb_pkg::OFS_BUF0, 8'h55);
    repeat (3) @(posedge sys_clk);
    irq(1'b0, 1'b1);
    wr(srb_pkg::OFS_STAT0, 8'h80);
    irq(1'b0, 1'b0);
    rd(srb_pkg::OFS_STAT0, 8'h80);
    // Let the frame finish so reset does not cut it
    wait (tx_q.size() == 0);
    // Reset in mid-run clears status and returns control to 8'h12
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(srb_pkg::OFS_STAT0, 8'h00);
    rd(srb_pkg::OFS_RXCTRL, 8'h12);
    repeat (2) @(posedge sys_clk);
    end_sim();
  end
endmodule
